// file: abu_pkg.sv
package abu_pkg;

    // ==========================================================
    // register offsets
    localparam logic [15:0] ABU_OFF_WAIT_STATUS  = 16'hfe00;
    localparam logic [15:0] ABU_OFF_AUX_CTRL     = 16'hfe02;
    localparam logic [15:0] ABU_OFF_FLAG_CLR     = 16'hfe03;
    localparam logic [15:0] ABU_OFF_ADDR_HIGH    = 16'hfe09;
    localparam logic [15:0] ABU_OFF_ADDR_LOW     = 16'hfe0a;
    localparam logic [15:0] ABU_OFF_STATUS_CTRL  = 16'hfe0b;
    localparam logic [15:0] ABU_OFF_IRQ_STATUS   = 16'hfe10;
    localparam logic [15:0] ABU_OFF_IRQ_CLEAR    = 16'hfe11;
    localparam logic [15:0] ABU_OFF_IRQ_ENABLE   = 16'hfe12;

    // ==========================================================
    // field positions
    localparam int ABU_BIT_MATCH_EN   = 7;
    localparam int ABU_BIT_ACTIVE     = 6;
    localparam int ABU_BIT_WAIT_FLAG  = 1;
    localparam int ABU_BIT_FLAG_CLR   = 7;
    localparam int ABU_BIT_WDOG_OFF   = 0;
    localparam int ABU_EV_MATCH       = 0;
    localparam int ABU_EV_SOFT        = 1;
    localparam int ABU_EV_WAKE        = 2;
    localparam int ABU_EV_W           = 3;

    // ==========================================================
    // reset values
    localparam logic [7:0] ABU_RST_WAIT_STATUS = 8'h10;
    localparam logic [7:0] ABU_RST_BYTE        = 8'h00;

endpackage : abu_pkg

// file: abu_sticky_bit.sv
`timescale 1ns/1ps
// sticky flag; set wins over clear
module abu_sticky_bit (
    input  wire logic sys_clk,
    input  wire logic rst_b,
    input  wire logic set_in,
    input  wire logic clr_in,
    output logic      flag_q
);
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            flag_q <= 1'b0;
        end else if (set_in) begin
            flag_q <= 1'b1;
        end else if (clr_in) begin
            flag_q <= 1'b0;
        end
    end
endmodule : abu_sticky_bit

// file: abu_addr_match.sv
`timescale 1ns/1ps
// registered compare of fetch address with breakpoint
module abu_addr_match #(
    parameter int AW = 16
) (
    input  wire logic          sys_clk,
    input  wire logic          rst_b,
    input  wire logic [AW-1:0] cpu_addr,
    input  wire logic          cpu_fetch,
    input  wire logic [AW-1:0] bkpt_addr,
    input  wire logic          match_en,
    output logic               hit_q
);
    wire hit_d = match_en && cpu_fetch && (cpu_addr == bkpt_addr);
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            hit_q <= 1'b0;
        end else begin
            hit_q <= hit_d;
        end
    end
endmodule : abu_addr_match

// file: abu_break_unit.sv
`timescale 1ns/1ps
module abu_break_unit
    import abu_pkg::*;
#(
    parameter int AW = 16
) (
    input  wire logic          sys_clk,
    input  wire logic          rst_b,
    input  wire logic [15:0]   reg_addr,
    input  wire logic [7:0]    reg_wdata,
    input  wire logic          reg_wr,
    input  wire logic          reg_rd,
    output logic [7:0]         reg_rdata,
    input  wire logic [AW-1:0] cpu_addr,
    input  wire logic          cpu_fetch,
    input  wire logic          cpu_in_wait,
    input  wire logic          cpu_in_stop,
    input  wire logic          cpu_break_exit,
    output logic               break_req,
    output logic               break_active,
    output logic               timer_halt,
    output logic               watchdog_disable,
    output logic               flag_clear_allow,
    output logic               low_power_wake,
    output logic               irq
);

    // ==========================================================
    // registers
    logic [7:0] addr_high_q;
    logic [7:0] addr_low_q;
    logic       match_en_q;
    logic       active_q;
    logic       flag_clr_en_q;
    logic       wdog_off_q;
    logic [7:0] rdata_q;
    logic [ABU_EV_W-1:0] irq_en_q;
    logic [ABU_EV_W-1:0] irq_stat;
    logic       wait_flag;
    logic       hit;

    // ==========================================================
    // decode
    wire wr_high   = reg_wr && (reg_addr == ABU_OFF_ADDR_HIGH);
    wire wr_low    = reg_wr && (reg_addr == ABU_OFF_ADDR_LOW);
    wire wr_sc     = reg_wr && (reg_addr == ABU_OFF_STATUS_CTRL);
    wire wr_ws     = reg_wr && (reg_addr == ABU_OFF_WAIT_STATUS);
    wire wr_fc     = reg_wr && (reg_addr == ABU_OFF_FLAG_CLR);
    wire wr_aux    = reg_wr && (reg_addr == ABU_OFF_AUX_CTRL);
    wire wr_iclr   = reg_wr && (reg_addr == ABU_OFF_IRQ_CLEAR);
    wire wr_ien    = reg_wr && (reg_addr == ABU_OFF_IRQ_ENABLE);
    wire [AW-1:0] bkpt_addr = AW'({addr_high_q, addr_low_q});

    // ==========================================================
    // break sources
    // address compare is registered, so the request follows the fetch by one cycle
    abu_addr_match #(.AW(AW)) u_match (
        .sys_clk   (sys_clk),
        .rst_b     (rst_b),
        .cpu_addr  (cpu_addr),
        .cpu_fetch (cpu_fetch),
        .bkpt_addr (bkpt_addr),
        .match_en  (match_en_q),
        .hit_q     (hit)
    );

    wire soft_break = wr_sc && reg_wdata[ABU_BIT_ACTIVE];
    // request goes straight out; the cpu decides the instruction boundary
    assign break_req = hit || soft_break;
    // a break while asleep wakes the cpu
    wire sleep_break = break_req && (cpu_in_wait || cpu_in_stop);

    // ==========================================================
    // control registers
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            addr_high_q   <= ABU_RST_BYTE;
            addr_low_q    <= ABU_RST_BYTE;
            match_en_q    <= 1'b0;
            flag_clr_en_q <= 1'b0;
            wdog_off_q    <= 1'b0;
            irq_en_q      <= '0;
        end else begin
            if (wr_high) begin
                addr_high_q <= reg_wdata;
            end
            if (wr_low) begin
                addr_low_q <= reg_wdata;
            end
            if (wr_sc) begin
                match_en_q <= reg_wdata[ABU_BIT_MATCH_EN];
            end
            if (wr_fc) begin
                flag_clr_en_q <= reg_wdata[ABU_BIT_FLAG_CLR];
            end
            if (wr_aux) begin
                wdog_off_q <= reg_wdata[ABU_BIT_WDOG_OFF];
            end
            if (wr_ien) begin
                irq_en_q <= reg_wdata[ABU_EV_W-1:0];
            end
        end
    end

    // ==========================================================
    // break-active bit: hardware set beats software clear
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            active_q <= 1'b0;
        end else if (break_req) begin
            active_q <= 1'b1;
        end else if (wr_sc && !reg_wdata[ABU_BIT_ACTIVE]) begin
            active_q <= 1'b0;
        end else if (cpu_break_exit) begin
            active_q <= 1'b0;
        end
    end

    // ==========================================================
    // wait flag
    abu_sticky_bit u_wait (
        .sys_clk (sys_clk),
        .rst_b   (rst_b),
        .set_in  (sleep_break),
        .clr_in  (wr_ws && !reg_wdata[ABU_BIT_WAIT_FLAG]),
        .flag_q  (wait_flag)
    );

    // ==========================================================
    // interrupt status, write one to clear
    wire [ABU_EV_W-1:0] ev_set = {sleep_break, soft_break, hit};
    genvar gi;
    generate
        for (gi = 0; gi < ABU_EV_W; gi++) begin : g_ev
            abu_sticky_bit u_ev (
                .sys_clk (sys_clk),
                .rst_b   (rst_b),
                .set_in  (ev_set[gi]),
                .clr_in  (wr_iclr && reg_wdata[gi]),
                .flag_q  (irq_stat[gi])
            );
        end
    endgenerate
    assign irq = |(irq_stat & irq_en_q);

    // ==========================================================
    // effects on the rest of the chip
    assign break_active     = active_q;
    assign timer_halt       = active_q;
    assign watchdog_disable = active_q && wdog_off_q;
    // outside break, clears are always allowed
    assign flag_clear_allow = !active_q || flag_clr_en_q;
    assign low_power_wake   = sleep_break;

    // ==========================================================
    // read mux
    logic [7:0] rd_mux;
    always_comb begin
        rd_mux = 8'h00;
        case (reg_addr)
            ABU_OFF_WAIT_STATUS: begin
                rd_mux = ABU_RST_WAIT_STATUS;
                rd_mux[ABU_BIT_WAIT_FLAG] = wait_flag;
            end
            ABU_OFF_AUX_CTRL:    rd_mux[ABU_BIT_WDOG_OFF] = wdog_off_q;
            ABU_OFF_FLAG_CLR:    rd_mux[ABU_BIT_FLAG_CLR] = flag_clr_en_q;
            ABU_OFF_ADDR_HIGH:   rd_mux = addr_high_q;
            ABU_OFF_ADDR_LOW:    rd_mux = addr_low_q;
            ABU_OFF_STATUS_CTRL: begin
                rd_mux[ABU_BIT_MATCH_EN] = match_en_q;
                rd_mux[ABU_BIT_ACTIVE]   = active_q;
            end
            ABU_OFF_IRQ_STATUS:  rd_mux[ABU_EV_W-1:0] = irq_stat;
            ABU_OFF_IRQ_ENABLE:  rd_mux[ABU_EV_W-1:0] = irq_en_q;
            default:             rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= reg_rd ? rd_mux : 8'h00;
        end
    end
    assign reg_rdata = rdata_q;

endmodule : abu_break_unit

// file: abu_properties.sv
`timescale 1ns/1ps
module abu_properties
    import abu_pkg::*;
(
    input wire logic        sys_clk,
    input wire logic        rst_b,
    input wire logic [15:0] reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic        reg_wr,
    input wire logic        cpu_fetch,
    input wire logic        cpu_in_wait,
    input wire logic        cpu_in_stop,
    input wire logic        cpu_break_exit,
    input wire logic        break_req,
    input wire logic        break_active,
    input wire logic        timer_halt,
    input wire logic        watchdog_disable,
    input wire logic        flag_clear_allow,
    input wire logic        low_power_wake
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    wire ctl_wr = reg_wr && reg_addr == ABU_OFF_STATUS_CTRL;
    // ==========================================================
    // break entry and exit steps
    sequence s_soft;
        ctl_wr && reg_wdata[ABU_BIT_ACTIVE];
    endsequence
    sequence s_soft_sleep;
        ctl_wr && reg_wdata[ABU_BIT_ACTIVE] && (cpu_in_wait || cpu_in_stop);
    endsequence
    sequence s_sw_clear;
        ctl_wr && !reg_wdata[ABU_BIT_ACTIVE] && !break_req;
    endsequence
    soft_req_a: assert property (s_soft |-> break_req)
        else $error("soft break without request");
    req_sets_a: assert property (break_req |=> break_active)
        else $error("request did not set active");
    req_cause_a: assert property (break_req && !ctl_wr |-> $past(cpu_fetch))
        else $error("request without fetch");
    sw_clear_a: assert property (s_sw_clear |=> !break_active)
        else $error("active not cleared by write");
    ret_exit_a: assert property (cpu_break_exit && !break_req |=> !break_active)
        else $error("active kept after return");
    active_hold_a: assert property (break_active && !cpu_break_exit && !ctl_wr |=> break_active)
        else $error("active dropped by itself");
    timer_halt_a: assert property (timer_halt == break_active)
        else $error("timer halt wrong");
    wdog_off_a: assert property (watchdog_disable |-> break_active)
        else $error("watchdog off outside break");
    flag_allow_a: assert property (!break_active |-> flag_clear_allow)
        else $error("flag clear blocked outside break");
    wake_pulse_a: assert property (low_power_wake == (break_req && (cpu_in_wait || cpu_in_stop)))
        else $error("wake pulse wrong");
    soft_wake_a: assert property (s_soft_sleep |-> low_power_wake)
        else $error("soft break while asleep did not wake");
    wake_active_a: assert property (low_power_wake |=> break_active)
        else $error("wake without break active");
endmodule : abu_properties

bind abu_break_unit abu_properties i_abu_properties (.*);

// file: abu_cpu_model.sv
`timescale 1ns/1ps
// cpu stand-in: fetch stream, jump to break vector, optional return op
module abu_cpu_model (
    input  wire logic        sys_clk,
    input  wire logic        break_req,
    input  wire logic        pc_load,
    input  wire logic [15:0] pc_val,
    input  wire logic        stall,
    input  wire logic [3:0]  ret_dly,
    output logic [15:0]      cpu_addr = 16'h0000,
    output logic             cpu_fetch = 1'b0,
    output logic             cpu_break_exit = 1'b0
);
    logic [3:0] cnt_q = 4'h0;
    always @(posedge sys_clk) begin
        cpu_fetch      <= !stall;
        cpu_break_exit <= cnt_q == 4'h1;
        cnt_q          <= (cnt_q != 4'h0) ? cnt_q - 4'h1 : 4'h0;
        if (pc_load) begin
            cpu_addr <= pc_val;
        end else if (break_req) begin
            cpu_addr <= 16'hfffc;
            cnt_q    <= ret_dly;
        end else if (cpu_fetch) begin
            cpu_addr <= cpu_addr + 16'h0001;
        end
    end
endmodule : abu_cpu_model

// file: tb_top.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin num_errors++; \
    $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module tb_top
    import abu_pkg::*;
;
    logic        sys_clk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, rd_d = 1'b0;
    logic        cpu_in_wait = 1'b0, cpu_in_stop = 1'b0, pc_load = 1'b0, stall = 1'b1;
    logic [15:0] reg_addr = 16'h0000, pc_val = 16'h0000, cpu_addr;
    logic [7:0]  reg_wdata = 8'h00, reg_rdata, ev, exp_q[$];
    logic [3:0]  ret_dly = 4'h0;
    logic        cpu_fetch, cpu_break_exit, break_req, break_active, timer_halt, irq;
    logic        watchdog_disable, flag_clear_allow, low_power_wake;
    logic [15:0] offs[8] = '{16'hfe00, 16'hfe02, 16'hfe03, 16'hfe09, 16'hfe0a, 16'hfe0b,
                             16'hfe10, 16'hfe12};
    int          num_errors = 0, checks_done = 0, seed = 40314, r;
    always #5 sys_clk = ~sys_clk;
    abu_break_unit i_abu_break_unit (.*);
    abu_cpu_model  i_abu_cpu_model (.*);
    // ==========================================================
    // register bus driver and read scoreboard
    task automatic acc(input int w, input logic [15:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        if (w == 0) exp_q.push_back(d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= (w != 0);
        reg_rd    <= (w == 0);
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        #1;
    endtask : acc
    always @(negedge sys_clk) begin
        if (rd_d) begin
            ev = exp_q.pop_front();
            `CHK("reg_rdata", ev, reg_rdata)
        end
        rd_d = reg_rd;
    end
    task automatic wrap_up;
        if (num_errors == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : wrap_up
    initial begin
        #200us;
        num_errors++;
        wrap_up();
    end
    // ==========================================================
    // scenarios
    initial begin
        repeat (8) @(posedge sys_clk);
        rst_b <= 1'b1;
        foreach (offs[i]) acc(0, offs[i], (i == 0) ? ABU_RST_WAIT_STATUS : 8'h00);
        repeat (3) begin
            r = $random(seed);
            acc(1, ABU_OFF_ADDR_HIGH, r[15:8]);
            acc(1, ABU_OFF_ADDR_LOW, r[7:0]);
            acc(0, ABU_OFF_ADDR_HIGH, r[15:8]);
            acc(0, ABU_OFF_ADDR_LOW, r[7:0]);
        end
        acc(1, ABU_OFF_ADDR_HIGH, 8'h12);
        acc(1, ABU_OFF_ADDR_LOW, 8'h34);
        acc(1, 16'hfe05, 8'hff);
        acc(0, 16'hfe05, 8'h00);
        acc(1, ABU_OFF_STATUS_CTRL, 8'h80);
        acc(1, ABU_OFF_IRQ_ENABLE, 8'h01);
        // matching address seen on a non-fetch cycle first
        @(posedge sys_clk);
        pc_val  <= 16'h1234;
        pc_load <= 1'b1;
        @(posedge sys_clk);
        pc_load <= 1'b0;
        repeat (4) @(posedge sys_clk);
        #1;
        `CHK("break_active", 1'b0, break_active)
        stall <= 1'b0;
        repeat (5) @(posedge sys_clk);
        #1;
        `CHK("break_active", 1'b1, break_active)
        `CHK("timer_halt", 1'b1, timer_halt)
        `CHK("flag_clear_allow", 1'b0, flag_clear_allow)
        `CHK("watchdog_disable", 1'b0, watchdog_disable)
        `CHK("irq", 1'b1, irq)
        acc(1, ABU_OFF_AUX_CTRL, 8'h01);
        `CHK("watchdog_disable", 1'b1, watchdog_disable)
        acc(1, ABU_OFF_FLAG_CLR, 8'h80);
        `CHK("flag_clear_allow", 1'b1, flag_clear_allow)
        acc(0, ABU_OFF_STATUS_CTRL, 8'hc0);
        acc(1, ABU_OFF_IRQ_CLEAR, 8'h01);
        `CHK("irq", 1'b0, irq)
        acc(1, ABU_OFF_STATUS_CTRL, 8'h80);
        `CHK("break_active", 1'b0, break_active)
        // soft break out of wait, match enable dropped by the same write
        cpu_in_wait <= 1'b1;
        acc(1, ABU_OFF_STATUS_CTRL, 8'h40);
        acc(0, ABU_OFF_STATUS_CTRL, 8'h40);
        acc(0, ABU_OFF_WAIT_STATUS, 8'h12);
        acc(1, ABU_OFF_WAIT_STATUS, 8'h00);
        acc(0, ABU_OFF_WAIT_STATUS, 8'h10);
        acc(1, ABU_OFF_STATUS_CTRL, 8'h00);
        cpu_in_wait <= 1'b0;
        // soft break out of stop, ended by the return op
        ret_dly     <= 4'h3;
        cpu_in_stop <= 1'b1;
        acc(1, ABU_OFF_STATUS_CTRL, 8'h40);
        repeat (6) @(posedge sys_clk);
        #1;
        `CHK("break_active", 1'b0, break_active)
        acc(0, ABU_OFF_WAIT_STATUS, 8'h12);
        acc(0, ABU_OFF_IRQ_STATUS, 8'h06);
        acc(1, ABU_OFF_IRQ_ENABLE, 8'h06);
        `CHK("irq", 1'b1, irq)
        acc(0, ABU_OFF_IRQ_ENABLE, 8'h06);
        // mid-run reset while a break is active
        ret_dly <= 4'h0;
        acc(1, ABU_OFF_STATUS_CTRL, 8'hc0);
        `CHK("break_active", 1'b1, break_active)
        @(posedge sys_clk);
        rst_b <= 1'b0;
        @(posedge sys_clk);
        rst_b <= 1'b1;
        #1;
        `CHK("break_active", 1'b0, break_active)
        `CHK("watchdog_disable", 1'b0, watchdog_disable)
        `CHK("irq", 1'b0, irq)
        foreach (offs[i]) acc(0, offs[i], (i == 0) ? ABU_RST_WAIT_STATUS : 8'h00);
        repeat (3) @(posedge sys_clk);
        wrap_up();
    end
endmodule : tb_top
